// ---- tccfg_defs.vh ----
// Constants of the capture/compare channel configuration block.
// Assumes a 200 MHz clock that also serves as the sampling clock.
//
// Function
// - Preload off: compare writes apply at once.
// - Preload on: writes hit copy; update transfers.
// - Channel 1 direction: output, input 1, 2, trigger.
// - Trigger mapping works only for internal sources.
// - Direction field frozen while channel enabled.
// - Channel 2: 01 input 2, 10 input 1.
// - Channel 4: 01 input 4, 10 input 3.
// - Channel 3: 01 input 3, 10 input 4.
// - Filter flips after N agreeing samples.
// - Codes 0 to 3: full rate, N 1,2,4,8.
// - Codes 4 to 15: divided rates, listed N.
// - Prescaler held reset while capture disabled.
// - Prescaler captures every 1, 2, 4, 8 edges.
// - Channels 3 and 4 input fields in second register.
// - Channels 3 and 4 output fields in second register.
// - Channels 5 and 6 output fields in third register.
// - Channels 7 to 9 preload bits 16, 20, 24.
// - Enable register at 0x24, bits 31:24 reserved.
// - Polarity picks rising or falling capture edge.
// - Enable bit gates the capture function.
// - Capture copies counter into compare value.
`ifndef TCCFG_DEFS_VH
`define TCCFG_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCCFG_CTRL_OFS 8'h08
`define TCCFG_MOD12_OFS 8'h18
`define TCCFG_MOD34_OFS 8'h1c
`define TCCFG_MOD59_OFS 8'h20
`define TCCFG_CCEN_OFS 8'h24
`define TCCFG_CMP1_OFS 8'h28
`define TCCFG_CMP2_OFS 8'h2c
`define TCCFG_CMP3_OFS 8'h30
`define TCCFG_CMP4_OFS 8'h34

// ----------------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------------
`define TCCFG_CTRL_MASK 32'h0000_000f
`define TCCFG_MOD12_MASK 32'h0000_ffff
`define TCCFG_MOD34_MASK 32'h0000_ffff
`define TCCFG_MOD59_MASK 32'h0111_fcfc
`define TCCFG_CCEN_MASK 32'h00cc_ffff
`define TCCFG_CMP_MASK 32'h0000_ffff
`define TCCFG_RST_VAL 32'h0000_0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TCCFG_CTRL_TRIGGER_SOURCE_SEL_HI 2
`define TCCFG_CTRL_OPM_BIT 3
`define TCCFG_DIR_OUTPUT 2'b00
`define TCCFG_DIR_OWN 2'b01
`define TCCFG_DIR_PAIR 2'b10
`define TCCFG_DIR_TRIG 2'b11
`define TCCFG_RESP_OKAY 2'b00
`define TCCFG_RESP_SLVERR 2'b10

`endif

// ---- tccfg_in_chan.v ----
// One capture input path: digital filter, edge detector and prescaler.
// Assumes the sample enable and filter length come from the parent.
module tccfg_in_chan (
  input wire clk,
  input wire rst_b,
  input wire sample_en,
  input wire [3:0] filt_len,
  input wire raw_in,
  input wire polarity,
  input wire capture_en,
  input wire [1:0] prescale,
  output reg capture_pulse
);

  reg level_q;
  reg [3:0] run_q;
  reg [2:0] evt_q;
  wire flip;
  wire edge_hit;
  reg [2:0] ratio_m1;

  // ----------------------------------------------------------------------
  // Digital filter
  // ----------------------------------------------------------------------
  // The level flips once enough consecutive samples differ from it.
  assign flip = sample_en && (raw_in != level_q) && (run_q + 4'h1 >= filt_len);

  // Count consecutive disagreeing samples; any agreeing sample restarts.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      level_q <= 1'b0;
      run_q <= 4'h0;
    end
    else if (sample_en)
    begin
      if (raw_in == level_q)
      begin
        run_q <= 4'h0;
      end
      else if (flip)
      begin
        level_q <= raw_in;
        run_q <= 4'h0;
      end
      else
      begin
        run_q <= run_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Edge detection and prescaler
  // ----------------------------------------------------------------------
  // Polarity 0 qualifies a rising edge, 1 a falling edge.
  assign edge_hit = flip && (raw_in == ~polarity);

  // Prescale ratio minus one.
  always @*
  begin
    case (prescale)
      2'b00: ratio_m1 = 3'd0;
      2'b01: ratio_m1 = 3'd1;
      2'b10: ratio_m1 = 3'd3;
      default: ratio_m1 = 3'd7;
    endcase
  end

  // Counts qualified edges; held cleared while capture is disabled.
  always @(posedge clk)
  begin
    if (!rst_b || !capture_en)
    begin
      evt_q <= 3'd0;
      capture_pulse <= 1'b0;
    end
    else
    begin
      capture_pulse <= 1'b0;
      if (edge_hit)
      begin
        if (evt_q >= ratio_m1)
        begin
          evt_q <= 3'd0;
          capture_pulse <= 1'b1;
        end
        else
        begin
          evt_q <= evt_q + 3'd1;
        end
      end
    end
  end

endmodule // tccfg_in_chan

// ---- tccfg_top.v ----
// Capture/compare channel configuration registers with AXI4-Lite access,
// input mapping, filtering, prescaling and compare preload for channels 1-4.
// Assumes timer inputs, counter value and update pulse are synchronous to clk.
//
// The AXI4-Lite slave port is this design's own decision.
`include "tccfg_defs.vh"

module tccfg_top (
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] timer_input,
  input wire internal_trigger_signal,
  input wire [15:0] counter_value,
  input wire update_event,
  output wire [63:0] compare_active,
  output reg [3:0] capture_event,
  output reg [31:0] cfg_mod12,
  output reg [31:0] cfg_mod34,
  output reg [31:0] cfg_mod5to9,
  output reg [31:0] cfg_chan_en,
  output reg [31:0] cfg_ctrl
);

  wire aw_take;
  wire ar_take;
  wire [31:0] be_mask;
  reg [31:0] wr_word;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  reg [4:0] div_q;
  wire [5:0] rate_en;
  wire [63:0] cmp_read;
  wire [3:0] cap_raw;
  wire [7:0] dir_all;
  wire [15:0] filt_all;
  wire [7:0] psc_all;
  wire [3:0] pen_all;
  wire [3:0] en_all;
  wire [3:0] pol_all;
  wire trig_ok;
  wire [31:0] cmp_ofs_all;

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  // Channels 3 and 4 reuse the channel 1 and 2 layout one register up.
  assign dir_all = {cfg_mod34[9:8], cfg_mod34[1:0], cfg_mod12[9:8], cfg_mod12[1:0]};
  assign filt_all = {cfg_mod34[15:12], cfg_mod34[7:4], cfg_mod12[15:12], cfg_mod12[7:4]};
  assign psc_all = {cfg_mod34[11:10], cfg_mod34[3:2], cfg_mod12[11:10], cfg_mod12[3:2]};
  // Output-mode preload enables share bit 2 and bit 10 of each register.
  assign pen_all = {cfg_mod34[10], cfg_mod34[2], cfg_mod12[10], cfg_mod12[2]};
  // Enable and polarity bits of channels 1-4 in the enable register.
  assign en_all = {cfg_chan_en[14], cfg_chan_en[10], cfg_chan_en[6], cfg_chan_en[2]};
  assign pol_all = {cfg_chan_en[15], cfg_chan_en[11], cfg_chan_en[7], cfg_chan_en[3]};
  // The trigger mapping is live only for an internal trigger source.
  assign trig_ok = ~cfg_ctrl[`TCCFG_CTRL_TRIGGER_SOURCE_SEL_HI];
  // Compare value offsets of channels 1-4, one byte each.
  assign cmp_ofs_all = {`TCCFG_CMP4_OFS, `TCCFG_CMP3_OFS, `TCCFG_CMP2_OFS, `TCCFG_CMP1_OFS};

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  assign aw_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign ar_take = s_axi_arready && s_axi_arvalid;
  assign be_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Write channel: address and data are taken together, then one response.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCCFG_RESP_OKAY;
    end
    else if (aw_take)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `TCCFG_RESP_OKAY : `TCCFG_RESP_SLVERR;
    end
    else if (s_axi_bvalid)
    begin
      if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
    else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
  end

  // Read channel: one read at a time, data held until accepted.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TCCFG_RST_VAL;
      s_axi_rresp <= `TCCFG_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `TCCFG_RESP_OKAY : `TCCFG_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else if (s_axi_arvalid && !s_axi_arready)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read decode; reserved bits are masked to zero by the stored value.
  always @*
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TCCFG_CTRL_OFS: rd_word = cfg_ctrl;
      `TCCFG_MOD12_OFS: rd_word = cfg_mod12;
      `TCCFG_MOD34_OFS: rd_word = cfg_mod34;
      `TCCFG_MOD59_OFS: rd_word = cfg_mod5to9;
      `TCCFG_CCEN_OFS: rd_word = cfg_chan_en;
      `TCCFG_CMP1_OFS: rd_word = {16'h0000, cmp_read[15:0]};
      `TCCFG_CMP2_OFS: rd_word = {16'h0000, cmp_read[31:16]};
      `TCCFG_CMP3_OFS: rd_word = {16'h0000, cmp_read[47:32]};
      `TCCFG_CMP4_OFS: rd_word = {16'h0000, cmp_read[63:48]};
      default:
      begin
        rd_word = `TCCFG_RST_VAL;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write decode and byte-lane merge; unknown offsets answer SLVERR.
  always @*
  begin
    wr_hit = 1'b1;
    case (s_axi_awaddr)
      `TCCFG_CTRL_OFS: wr_word = cfg_ctrl;
      `TCCFG_MOD12_OFS: wr_word = cfg_mod12;
      `TCCFG_MOD34_OFS: wr_word = cfg_mod34;
      `TCCFG_MOD59_OFS: wr_word = cfg_mod5to9;
      `TCCFG_CCEN_OFS: wr_word = cfg_chan_en;
      `TCCFG_CMP1_OFS, `TCCFG_CMP2_OFS, `TCCFG_CMP3_OFS, `TCCFG_CMP4_OFS: wr_word = `TCCFG_RST_VAL;
      default:
      begin
        wr_word = `TCCFG_RST_VAL;
        wr_hit = 1'b0;
      end
    endcase
    wr_word = (wr_word & ~be_mask) | (s_axi_wdata & be_mask);
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Direction fields keep their value while the channel is enabled.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_ctrl <= `TCCFG_RST_VAL;
      cfg_mod12 <= `TCCFG_RST_VAL;
      cfg_mod34 <= `TCCFG_RST_VAL;
      cfg_mod5to9 <= `TCCFG_RST_VAL;
      cfg_chan_en <= `TCCFG_RST_VAL;
    end
    else if (aw_take)
    begin
      case (s_axi_awaddr)
        `TCCFG_CTRL_OFS: cfg_ctrl <= wr_word & `TCCFG_CTRL_MASK;
        `TCCFG_MOD12_OFS:
        begin
          cfg_mod12 <= wr_word & `TCCFG_MOD12_MASK;
          if (en_all[0]) cfg_mod12[1:0] <= cfg_mod12[1:0];
          if (en_all[1]) cfg_mod12[9:8] <= cfg_mod12[9:8];
        end
        `TCCFG_MOD34_OFS:
        begin
          cfg_mod34 <= wr_word & `TCCFG_MOD34_MASK;
          if (en_all[2]) cfg_mod34[1:0] <= cfg_mod34[1:0];
          if (en_all[3]) cfg_mod34[9:8] <= cfg_mod34[9:8];
        end
        `TCCFG_MOD59_OFS: cfg_mod5to9 <= wr_word & `TCCFG_MOD59_MASK;
        `TCCFG_CCEN_OFS: cfg_chan_en <= wr_word & `TCCFG_CCEN_MASK;
        default: cfg_ctrl <= cfg_ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sample-rate divider
  // ----------------------------------------------------------------------
  // Free-running count gives enables at the sample clock over 1 to 32.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_q <= 5'd0;
    end
    else
    begin
      div_q <= div_q + 5'd1;
    end
  end

  assign rate_en[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k < 6; k = k + 1)
    begin : g_rate
      assign rate_en[k] = &div_q[k-1:0];
    end
  endgenerate

  // Filter code to sample-rate index.
  function [2:0] tccfg_rate_sel;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'h2, 4'h3: tccfg_rate_sel = 3'd0;
        4'h4, 4'h5: tccfg_rate_sel = 3'd1;
        4'h6, 4'h7: tccfg_rate_sel = 3'd2;
        4'h8, 4'h9: tccfg_rate_sel = 3'd3;
        4'ha, 4'hb, 4'hc: tccfg_rate_sel = 3'd4;
        default: tccfg_rate_sel = 3'd5;
      endcase
    end
  endfunction

  // Filter code to the number of agreeing samples.
  function [3:0] tccfg_filt_len;
    input [3:0] code;
    begin
      case (code)
        4'h0: tccfg_filt_len = 4'd1;
        4'h1: tccfg_filt_len = 4'd2;
        4'h2: tccfg_filt_len = 4'd4;
        4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: tccfg_filt_len = 4'd8;
        4'h4, 4'h6, 4'h8, 4'hb, 4'he: tccfg_filt_len = 4'd6;
        default: tccfg_filt_len = 4'd5;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Per-channel input mapping, capture and compare value
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_ch
      reg [15:0] pre_q;
      reg [15:0] act_q;
      reg mapped;
      wire [1:0] dir;
      wire [3:0] filt;
      wire is_input;
      wire cmp_wr;

      assign dir = dir_all[2*i+1:2*i];
      assign filt = filt_all[4*i+3:4*i];
      assign is_input = (dir != `TCCFG_DIR_OUTPUT);

      // Own input for 01, neighbour of the pair for 10, trigger for 11.
      always @*
      begin
        case (dir)
          `TCCFG_DIR_OWN: mapped = timer_input[i];
          `TCCFG_DIR_PAIR: mapped = timer_input[i^1];
          `TCCFG_DIR_TRIG: mapped = internal_trigger_signal & trig_ok;
          default: mapped = 1'b0;
        endcase
      end

      tccfg_in_chan u_in (
        .clk(clk),
        .rst_b(rst_b),
        .sample_en(rate_en[tccfg_rate_sel(filt)]),
        .filt_len(tccfg_filt_len(filt)),
        .raw_in(mapped),
        .polarity(pol_all[i]),
        .capture_en(en_all[i] & is_input),
        .prescale(psc_all[2*i+1:2*i]),
        .capture_pulse(cap_raw[i])
      );

      assign cmp_wr = aw_take && !is_input &&
                      (s_axi_awaddr == cmp_ofs_all[8*i+7:8*i]);

      // Compare value with preload copy; capture overwrites both copies.
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          pre_q <= 16'h0000;
          act_q <= 16'h0000;
          capture_event[i] <= 1'b0;
        end
        else
        begin
          capture_event[i] <= cap_raw[i] & is_input;
          if (cap_raw[i] && is_input)
          begin
            pre_q <= counter_value;
            act_q <= counter_value;
          end
          else
          begin
            if (cmp_wr)
            begin
              pre_q <= (pre_q & ~be_mask[15:0]) | (s_axi_wdata[15:0] & be_mask[15:0]);
            end
            if (cmp_wr && !pen_all[i])
            begin
              act_q <= (pre_q & ~be_mask[15:0]) | (s_axi_wdata[15:0] & be_mask[15:0]);
            end
            else if (update_event && pen_all[i] && !is_input)
            begin
              act_q <= pre_q;
            end
          end
        end
      end

      assign cmp_read[16*i+15:16*i] = pre_q;
      assign compare_active[16*i+15:16*i] = act_q;
    end
  endgenerate

endmodule // tccfg_top

// ---- tccfg_sva.sv ----
// Checker for tccfg_top: field storage, direction locks, preload and capture gating.
// Assumes it is bound into tccfg_top and sees only that module's ports.
module tccfg_sva (
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire update_event,
  input wire [63:0] compare_active,
  input wire [3:0] capture_event,
  input wire [31:0] cfg_mod12,
  input wire [31:0] cfg_mod34,
  input wire [31:0] cfg_mod5to9,
  input wire [31:0] cfg_chan_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks share one clock and stay quiet while reset is applied.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Without preload a compare write lands in the active copy on the next edge.
  cmp_direct_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hf
    && s_axi_awaddr == 8'h28 && cfg_mod12[2:0] == 3'h0
    |=> compare_active[15:0] == $past(s_axi_wdata[15:0]))
    else $error("compare write did not apply at once");
  // With preload the active copy moves only after an update pulse.
  cmp_preload_a: assert property (
    $changed(compare_active[15:0]) && $past(rst_b) && $past(cfg_mod12[2:0]) == 3'h4
    |-> $past(update_event))
    else $error("preloaded compare moved without update");
  dir1_frozen_a: assert property (
    $past(cfg_chan_en[2]) && $past(rst_b) |-> $stable(cfg_mod12[1:0]))
    else $error("ch1 direction changed while enabled");
  dir4_frozen_a: assert property (
    $past(cfg_chan_en[14]) && $past(rst_b) |-> $stable(cfg_mod34[9:8]))
    else $error("ch4 direction changed while enabled");
  // A capture needs the channel enabled and in input mode.
  cap_gated_a: assert property (
    capture_event[0] |-> ($past(cfg_chan_en[2]) || $past(cfg_chan_en[2], 2))
    && $past(cfg_mod12[1:0], 2) != 2'h0)
    else $error("capture while channel disabled");
  res_mode59_a: assert property ((cfg_mod5to9 & 32'hfeee_0303) == 32'h0000_0000)
    else $error("reserved bit set in mode register three");
  res_enable_a: assert property (cfg_chan_en[31:24] == 8'h00)
    else $error("reserved bit set in enable register");
  res_mode_hi_a: assert property (
    cfg_mod12[31:16] == 16'h0000 && cfg_mod34[31:16] == 16'h0000)
    else $error("reserved upper half set in mode register");
endmodule // tccfg_sva

bind tccfg_top tccfg_sva u_chk (
  .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .update_event, .compare_active, .capture_event,
  .cfg_mod12, .cfg_mod34, .cfg_mod5to9, .cfg_chan_en
);

// ---- tccfg_bench.sv ----
// Self-checking bench for tccfg_top: register map, input mapping, filter,
// prescaler, capture value and compare preload.
// Assumes a single AXI4-Lite master and inputs changed just after clock edges.
module tccfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } tccfg_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] timer_input = 4'h0;
  logic internal_trigger_signal = 1'b0;
  logic [15:0] counter_value = 16'hbeef;
  logic update_event = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [63:0] compare_active;
  wire [3:0] capture_event;
  wire [31:0] cfg_mod12, cfg_mod34, cfg_mod5to9, cfg_chan_en, cfg_ctrl;
  wire [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
  int bad_count = 0;
  int comparisons = 0;
  int cnt[4] = '{default: 0};
  logic [7:0] ofs[5] = '{8'h08, 8'h18, 8'h1c, 8'h20, 8'h24};
  logic [3:0] dm[2][4] = '{'{4'h1, 4'h2, 4'h4, 4'h8}, '{4'h2, 4'h1, 4'h8, 4'h4}};
  // Each row writes a word, then reads it back with the expected answer.
  tccfg_row_t rows[10] = '{
    '{8'h18, 32'hffff_ffff, 32'h0000_ffff, 2'h0}, '{8'h1c, 32'hffff_ffff, 32'h0000_ffff, 2'h0},
    '{8'h20, 32'hffff_ffff, 32'h0111_fcfc, 2'h0}, '{8'h24, 32'hffff_ffff, 32'h00cc_ffff, 2'h0},
    '{8'h18, 32'h0000_0000, 32'h0000_0303, 2'h0}, '{8'h1c, 32'h0000_0000, 32'h0000_0303, 2'h0},
    '{8'h24, 32'h0000_0000, 32'h0000_0000, 2'h0}, '{8'h18, 32'h0000_0000, 32'h0000_0000, 2'h0},
    '{8'h1c, 32'h0000_0000, 32'h0000_0000, 2'h0}, '{8'h40, 32'hffff_ffff, 32'h0000_0000, 2'h2}};

  tccfg_top u_tccfg_top (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_input, .internal_trigger_signal, .counter_value, .update_event, .compare_active,
    .capture_event, .cfg_mod12, .cfg_mod34, .cfg_mod5to9, .cfg_chan_en, .cfg_ctrl
  );

  // The clock toggles every half period of 2.5 ns.
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    begin
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        bad_count++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Waits edge by edge for one handshake flag, giving up after 100 cycles.
  task automatic wt(input int s);
    int i;
    begin
      i = 0;
      @(posedge clk);
      while (hs[s] !== 1'b1)
      begin
        i++;
        if (i > 99)
        begin
          bad_count++;
          $display("[ERR] %0t handshake timeout", $time);
          end_sim();
        end
        @(posedge clk);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wt(0);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wt(1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(r));
      @(posedge clk);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wt(2);
      s_axi_arvalid <= 1'b0;
      wt(3);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(r));
      @(posedge clk);
    end
  endtask

  // Holds the inputs for w cycles while counting capture pulses per channel.
  task automatic lv(input logic [4:0] m, input int w);
    begin
      {internal_trigger_signal, timer_input} <= m;
      repeat (w)
      begin
        @(posedge clk);
        foreach (cnt[k])
          cnt[k] += int'(capture_event[k] === 1'b1);
      end
    end
  endtask

  task automatic pul(input logic [4:0] m, input int n, input int w);
    repeat (n)
    begin
      lv(m, w);
      lv(5'h00, w);
    end
  endtask

  task automatic ck(input logic [3:0] m, input int n);
    begin
      foreach (cnt[k])
        chk(32'(cnt[k]), m[k] ? 32'(n) : 32'h0000_0000);
      cnt = '{default: 0};
    end
  endtask

  task automatic cf(input logic [31:0] m12, input logic [31:0] m34, input logic [31:0] en);
    begin
      wr(8'h24, 32'h0000_0000);
      wr(8'h18, m12);
      wr(8'h1c, m34);
      wr(8'h24, en);
    end
  endtask

  // Main sequence: table rows first, then the capture and compare cases.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].e, rows[i].r);
    end
    chk(cfg_mod5to9, 32'h0111_fcfc);
    chk(cfg_mod12 | cfg_mod34 | cfg_chan_en, 32'h0000_0000);
    for (int c = 0; c < 2; c++)
    begin
      cf(32'h0000_0101 << c, 32'h0000_0101 << c, 32'h0000_4444);
      for (int k = 0; k < 4; k++)
      begin
        pul(5'(1 << k), 2, 12);
        ck(dm[c][k], 2);
      end
    end
    cf(32'h0000_0303, 32'h0000_0303, 32'h0000_4444);
    pul(5'h10, 2, 12);
    ck(4'hf, 2);
    wr(8'h08, 32'h0000_0004);
    rd(8'h08, 32'h0000_0004);
    chk(cfg_ctrl, 32'h0000_0004);
    pul(5'h10, 2, 12);
    ck(4'h0, 2);
    cf(32'h0000_0001, 32'h0000_0000, 32'h0000_000c);
    chk(cfg_chan_en, 32'h0000_000c);
    lv(5'h01, 12);
    ck(4'h0, 0);
    lv(5'h00, 12);
    ck(4'h1, 1);
    for (int p = 0; p < 4; p++)
    begin
      cf(32'h0000_0001 | (32'(p) << 2), 32'h0000_0000, 32'h0000_0004);
      pul(5'h01, 8, 12);
      ck(4'h1, 8 >> p);
    end
    rd(8'h28, 32'h0000_beef);
    wr(8'h28, 32'h0000_1111);
    rd(8'h28, 32'h0000_beef);
    cf(32'h0000_0005, 32'h0000_0000, 32'h0000_0004);
    pul(5'h01, 1, 12);
    wr(8'h24, 32'h0000_0000);
    wr(8'h24, 32'h0000_0004);
    pul(5'h01, 1, 12);
    ck(4'h0, 0);
    pul(5'h01, 1, 12);
    ck(4'h1, 1);
    cf(32'h0000_0031, 32'h0000_0000, 32'h0000_0004);
    pul(5'h01, 1, 6);
    ck(4'h0, 0);
    pul(5'h01, 1, 12);
    ck(4'h1, 1);
    cf(32'h0000_00f1, 32'h0000_0000, 32'h0000_0004);
    pul(5'h01, 1, 200);
    ck(4'h0, 0);
    pul(5'h01, 1, 300);
    ck(4'h1, 1);
    cf(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    wr(8'h28, 32'h0000_1234);
    chk(32'(compare_active[15:0]), 32'h0000_1234);
    // Software turns preload on while channel 1 stays in output mode.
    wr(8'h18, 32'h0000_00c4);
    wr(8'h28, 32'h0000_5678);
    chk(32'(compare_active[15:0]), 32'h0000_1234);
    rd(8'h28, 32'h0000_5678);
    update_event <= 1'b1;
    @(posedge clk);
    update_event <= 1'b0;
    @(posedge clk);
    chk(32'(compare_active[15:0]), 32'h0000_5678);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (ofs[i])
      rd(ofs[i], 32'h0000_0000);
    chk(32'(compare_active[15:0]), 32'h0000_0000);
    end_sim();
  end
endmodule // tccfg_bench
